/* common/urc_cfg.svh */
// Purpose: Register offsets, reset values and field encodings of the RXCMD status block
// Assumes: Included by its bare name wherever the constants are needed
// Notes: Definitions only
`ifndef URC_CFG_SVH
`define URC_CFG_SVH

`define URC_REG_CTRL 4'h0
`define URC_REG_IRQ_STAT 4'h4
`define URC_REG_IRQ_MASK 4'h8
`define URC_REG_RXCMD 4'hC

`define URC_CTRL_FORCE_BIT 0
`define URC_CTRL_OTG_BIT 1
`define URC_CTRL_OTG_RST 1'b1

`define URC_IRQ_W 4
`define URC_IRQ_ID_BIT 0
`define URC_IRQ_RID_BIT 1
`define URC_IRQ_VBUS_BIT 2
`define URC_IRQ_LINE_BIT 3
`define URC_IRQ_MASK_RST 4'h3

`define URC_VBUS_BELOW_END 2'h0
`define URC_VBUS_END_TO_SESS 2'h1
`define URC_VBUS_SESS_TO_VLD 2'h2
`define URC_VBUS_VALID 2'h3

`define URC_EVT_NONE 2'h0
`define URC_EVT_RX_ACTIVE 2'h1
`define URC_EVT_RX_ERROR 2'h3
`define URC_EVT_DISCONNECT 2'h2

`endif

/* common/urc_pkg.sv */
// Purpose: Types shared by the RXCMD status block
// Assumes: Constants live in urc_cfg.svh
// Notes: Struct fields are listed from the most significant bit down
package urc_pkg;

  typedef enum logic [2:0] {
    S_START = 3'b000,
    S_LINK = 3'b001,
    S_TA_UP = 3'b010,
    S_OWN = 3'b011,
    S_TA_DN = 3'b100
  } urc_state_t;

  // Analog comparator and pin levels, asynchronous to ref_clk
  typedef struct packed {
    logic rid_done;
    logic id;
    logic vbus_vld;
    logic sess_vld;
    logic sess_end;
    logic dm;
    logic dp;
  } urc_pins_t;

  typedef struct packed {
    logic low_power;
    logic serial;
    logic carkit;
  } urc_mode_t;

  typedef struct packed {
    logic active;
    logic error;
    logic host_disc;
    logic valid;
    logic [7:0] data;
  } urc_rx_t;

  typedef struct packed {
    logic alt_int;
    logic id;
    logic [1:0] rx_event;
    logic [1:0] vbus;
    logic [1:0] line;
  } urc_rxcmd_t;

endpackage

/* hdl/urc_sync.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Each bit is an independent level
// Notes: Bits may resolve one cycle apart from each other
`timescale 1ns/1ns
module urc_sync #(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[gi];
          sync_q <= meta_q;
        end
      end
      assign sync_out[gi] = sync_q;
    end
  endgenerate

endmodule // urc_sync

/* hdl/urc_rxcmd.sv */
// Purpose: Builds the RXCMD status byte and decides when it goes out on the ULPI bus
// Assumes: Link, receiver, transmitter and mode logic run on ref_clk; pins_a is asynchronous
// Notes: The byte always carries the values sampled in the cycle before it is driven
`timescale 1ns/1ns
`include "urc_cfg.svh"

// Functional notes
// - Send only in synchronous mode owning bus
// - Line change with DIR low takes bus
// - During receive, status byte when NXT low
// - During transmit, hold bytes until STP seen
// - Send on VBUS or ID comparator change
// - Send after start-up DIR release, STP low
// - Send on leaving special mode after STP
// - Line state in bits one and zero
// - Bits three-two encode VBUS level
// - Bits five-four encode receive events
// - Bit six follows ID pin level
// - Bit seven flags unmasked latched interrupt
// - ID change, resistance done raise latch
// - OTG enable adds VBUS and ID
// - One undriven turnaround cycle per DIR change
// - Bit zero is D+, bit one D-
module urc_rxcmd (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire urc_pkg::urc_pins_t pins_a,
  input wire urc_pkg::urc_rx_t rx,
  input wire logic tx_active,
  input wire urc_pkg::urc_mode_t mode,
  input wire logic pll_locked,
  input wire logic ulpi_stp,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic irq
);

  logic [6:0] pins_raw;
  urc_pkg::urc_pins_t pin_s;
  urc_pkg::urc_state_t st_q, st_d;
  urc_pkg::urc_rxcmd_t cur_cmd, sent_q;
  logic dir_q, dir_d, nxt_q, nxt_d, oe_q, oe_d;
  logic [7:0] data_q, data_d, rdata_q;
  logic irq_q, otg_en_q, force_q, boot_q, tx_stp_q, mode_stp_q, alt_prev_q;
  logic [`URC_IRQ_W-1:0] stat_q, mask_q, irq_ev;
  logic id_prev_q, rid_prev_q;
  logic [1:0] arm_q;
  logic [1:0] vbus_prev_q, line_prev_q;
  logic alt_now, sync_ok, hold, need, send, mode_exit, force_set, alt_int;
  logic wr_ctrl, wr_stat, wr_mask;

  urc_sync #(.WIDTH(7)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(pins_a),
    .sync_out(pins_raw)
  );
  assign pin_s = urc_pkg::urc_pins_t'(pins_raw);

  // Register port
  assign wr_ctrl = reg_wr && (reg_addr == `URC_REG_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `URC_REG_IRQ_STAT);
  assign wr_mask = reg_wr && (reg_addr == `URC_REG_IRQ_MASK);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      otg_en_q <= `URC_CTRL_OTG_RST;
      mask_q <= `URC_IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        otg_en_q <= reg_wdata[`URC_CTRL_OTG_BIT];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[`URC_IRQ_W-1:0];
      end
    end
  end

  // Unmapped or idle cycles read as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `URC_REG_CTRL: rdata_q <= {6'h00, otg_en_q, 1'b0};
        `URC_REG_IRQ_STAT: rdata_q <= {4'h0, stat_q};
        `URC_REG_IRQ_MASK: rdata_q <= {4'h0, mask_q};
        `URC_REG_RXCMD: rdata_q <= sent_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Interrupt latch; a new event outranks a write-one clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      id_prev_q <= 1'b0;
      rid_prev_q <= 1'b0;
      vbus_prev_q <= 2'h0;
      line_prev_q <= 2'h0;
      arm_q <= 2'h0;
    end else begin
      if (arm_q != 2'h3) begin
        arm_q <= arm_q + 2'h1;
      end
      id_prev_q <= pin_s.id;
      rid_prev_q <= pin_s.rid_done;
      vbus_prev_q <= cur_cmd.vbus;
      line_prev_q <= cur_cmd.line;
    end
  end

  // History starts at zero, so edges are ignored until real pin levels are held
  always_comb begin
    irq_ev = '0;
    if (arm_q == 2'h3) begin
      irq_ev[`URC_IRQ_ID_BIT] = pin_s.id != id_prev_q;
      irq_ev[`URC_IRQ_RID_BIT] = pin_s.rid_done && !rid_prev_q;
      irq_ev[`URC_IRQ_VBUS_BIT] = cur_cmd.vbus != vbus_prev_q;
      irq_ev[`URC_IRQ_LINE_BIT] = cur_cmd.line != line_prev_q;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata[`URC_IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  assign alt_int = |(stat_q & mask_q);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= alt_int;
    end
  end

  // Status byte from the latest sampled values
  always_comb begin
    cur_cmd.line = {pin_s.dm, pin_s.dp};
    if (!otg_en_q) begin
      cur_cmd.vbus = `URC_VBUS_BELOW_END;
    end else if (pin_s.vbus_vld) begin
      cur_cmd.vbus = `URC_VBUS_VALID;
    end else if (pin_s.sess_vld) begin
      cur_cmd.vbus = `URC_VBUS_SESS_TO_VLD;
    end else if (!pin_s.sess_end) begin
      cur_cmd.vbus = `URC_VBUS_END_TO_SESS;
    end else begin
      cur_cmd.vbus = `URC_VBUS_BELOW_END;
    end
    if (rx.host_disc) begin
      cur_cmd.rx_event = `URC_EVT_DISCONNECT;
    end else if (rx.active) begin
      cur_cmd.rx_event = rx.error ? `URC_EVT_RX_ERROR : `URC_EVT_RX_ACTIVE;
    end else begin
      cur_cmd.rx_event = `URC_EVT_NONE;
    end
    cur_cmd.id = otg_en_q && pin_s.id;
    cur_cmd.alt_int = alt_int;
  end

  // Scheduling
  assign alt_now = mode.low_power || mode.serial || mode.carkit;
  assign sync_ok = !alt_now && (st_q != urc_pkg::S_START);
  assign hold = tx_active && !tx_stp_q;
  // Comparing with the last byte sent merges coinciding changes into one byte
  assign need = (cur_cmd != sent_q) || force_q;
  assign mode_exit = alt_prev_q && !alt_now;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_stp_q <= 1'b0;
    end else if (!tx_active) begin
      tx_stp_q <= 1'b0;
    end else if (ulpi_stp) begin
      tx_stp_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      alt_prev_q <= 1'b0;
      mode_stp_q <= 1'b0;
    end else begin
      alt_prev_q <= alt_now;
      if (mode_exit) begin
        mode_stp_q <= 1'b0;
      end else if (alt_now && ulpi_stp) begin
        mode_stp_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_q <= 1'b1;
    end else if (st_q == urc_pkg::S_TA_DN) begin
      boot_q <= 1'b0;
    end
  end

  assign force_set = (wr_ctrl && reg_wdata[`URC_CTRL_FORCE_BIT])
    || (st_q == urc_pkg::S_TA_DN && boot_q && !ulpi_stp)
    || (mode_exit && mode_stp_q)
    || (tx_active && ulpi_stp && !tx_stp_q);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      force_q <= 1'b0;
    end else if (force_set) begin
      force_q <= 1'b1;
    end else if (send) begin
      force_q <= 1'b0;
    end
  end

  // Bus state and the values the pins take in the next cycle
  always_comb begin
    st_d = st_q;
    case (st_q)
      urc_pkg::S_START: begin
        if (pll_locked) begin
          st_d = urc_pkg::S_TA_DN;
        end
      end
      urc_pkg::S_LINK: begin
        if (sync_ok && (rx.active || (need && !hold))) begin
          st_d = urc_pkg::S_TA_UP;
        end
      end
      urc_pkg::S_TA_UP: st_d = sync_ok ? urc_pkg::S_OWN : urc_pkg::S_TA_DN;
      urc_pkg::S_OWN: begin
        if (!(rx.active && sync_ok)) begin
          st_d = urc_pkg::S_TA_DN;
        end
      end
      urc_pkg::S_TA_DN: st_d = urc_pkg::S_LINK;
      default: st_d = urc_pkg::S_LINK;
    endcase
    dir_d = st_d == urc_pkg::S_START || st_d == urc_pkg::S_TA_UP || st_d == urc_pkg::S_OWN;
    oe_d = st_d == urc_pkg::S_OWN;
    nxt_d = 1'b0;
    data_d = 8'h00;
    send = 1'b0;
    if (st_d == urc_pkg::S_TA_UP) begin
      nxt_d = rx.active;
    end else if (st_d == urc_pkg::S_OWN) begin
      if (rx.active && rx.valid) begin
        nxt_d = 1'b1;
        data_d = rx.data;
      end else begin
        data_d = cur_cmd;
        send = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= urc_pkg::S_START;
      dir_q <= 1'b1;
      nxt_q <= 1'b0;
      oe_q <= 1'b0;
      data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      nxt_q <= nxt_d;
      oe_q <= oe_d;
      data_q <= data_d;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sent_q <= '0;
    end else if (send) begin
      sent_q <= cur_cmd;
    end
  end

  assign reg_rdata = rdata_q;
  assign ulpi_dir = dir_q;
  assign ulpi_nxt = nxt_q;
  assign ulpi_data_out = data_q;
  assign ulpi_data_oe = oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_own_sync;
    oe_q |-> dir_q && $past(sync_ok);
  endproperty
  a_own_sync: assert property (p_own_sync) else $error("bus driven outside sync mode");
  property p_turnaround;
    $changed(dir_q) |-> !oe_q;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("data driven on turnaround");
  property p_line_take;
    (st_q == urc_pkg::S_LINK && sync_ok && !hold && cur_cmd.line != sent_q.line)
      |=> dir_q ##1 oe_q;
  endproperty
  a_line_take: assert property (p_line_take) else $error("line change not sent");
  property p_rx_stay;
    (st_q == urc_pkg::S_OWN && rx.active && sync_ok) |=> oe_q && dir_q;
  endproperty
  a_rx_stay: assert property (p_rx_stay) else $error("bus dropped during receive");
  property p_cmd_value;
    (oe_q && !nxt_q) |-> data_q == $past(cur_cmd) && data_q[1:0] == $past({pin_s.dm, pin_s.dp});
  endproperty
  a_cmd_value: assert property (p_cmd_value) else $error("status byte stale");
  property p_tx_hold;
    (st_q == urc_pkg::S_LINK && hold && !rx.active) |=> !dir_q;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("status sent during transmit");
  property p_cmp_change;
    ($changed(pin_s.vbus_vld) && otg_en_q && st_q == urc_pkg::S_LINK && sync_ok && !hold)
      |=> dir_q ##1 (oe_q && !nxt_q);
  endproperty
  a_cmp_change: assert property (p_cmp_change) else $error("VBUS change not sent");
  property p_boot;
    (st_q == urc_pkg::S_TA_DN && boot_q && !ulpi_stp) |=> force_q ##1 (dir_q || !$past(sync_ok) || $past(hold));
  endproperty
  a_boot: assert property (p_boot) else $error("no status after start-up");
  property p_mode_exit;
    (mode_exit && mode_stp_q) |=> force_q;
  endproperty
  a_mode_exit: assert property (p_mode_exit) else $error("no status after mode exit");
  property p_vbus_enc;
    (otg_en_q && pin_s.vbus_vld) |-> cur_cmd.vbus == `URC_VBUS_VALID;
  endproperty
  a_vbus_enc: assert property (p_vbus_enc) else $error("VBUS code wrong");
  property p_disc_enc;
    rx.host_disc |-> cur_cmd.rx_event == `URC_EVT_DISCONNECT;
  endproperty
  a_disc_enc: assert property (p_disc_enc) else $error("disconnect code wrong");

  property p_alt;
    cur_cmd.alt_int |=> irq_q;
  endproperty
  a_alt: assert property (p_alt) else $error("alt interrupt not raised");

  property p_id_latch;
    (arm_q == 2'h3 && $changed(pin_s.id)) |=> stat_q[`URC_IRQ_ID_BIT];
  endproperty
  a_id_latch: assert property (p_id_latch) else $error("ID change not latched");

  c_rx_packet: cover property (st_q == urc_pkg::S_OWN && nxt_q ##1 oe_q && !nxt_q);
  c_tx_return: cover property (tx_active && ulpi_stp ##[1:8] (oe_q && !nxt_q));
  c_boot_cmd: cover property (boot_q && st_q == urc_pkg::S_TA_DN ##[1:4] oe_q);

endmodule // urc_rxcmd

/* testbench/urc_link_model.sv */
// Purpose: Link-side partner that collects status bytes and pulses STP
// Assumes: Bus data from the device is sampled on ref_clk
// Notes: Link never drives data here, so a turnaround clash cannot happen
`timescale 1ns/1ns
module urc_link_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic stp_go,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe,
  output logic ulpi_stp,
  output logic [7:0] last_byte,
  output int byte_cnt
);
  logic dir_q;

  assign ulpi_stp = stp_go;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dir_q <= 1'b0;
      last_byte <= 8'h00;
      byte_cnt <= 0;
    end else begin
      dir_q <= ulpi_dir;
      // Skip the turnaround cycle after DIR rises
      if (ulpi_dir && dir_q && ulpi_data_oe && !ulpi_nxt) begin
        last_byte <= ulpi_data_out;
        byte_cnt <= byte_cnt + 1;
      end
    end
  end
endmodule // urc_link_model

/* testbench/tb.sv */
// Purpose: Self-checking bench for the status byte block
// Assumes: Link model sits on the ULPI side
// Notes: Byte checks poll for the latest byte, as merged triggers are legal
`timescale 1ns/1ns
`include "urc_cfg.svh"
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  urc_pkg::urc_pins_t pins_a = 7'h19;
  urc_pkg::urc_rx_t rx = 12'h000;
  urc_pkg::urc_mode_t mode = 3'h0;
  logic tx_active = 1'b0;
  logic pll_locked = 1'b0;
  logic stp_go = 1'b0;
  logic ulpi_stp, ulpi_dir, ulpi_nxt, ulpi_data_oe, irq;
  logic [7:0] ulpi_data_out;
  logic [7:0] last_byte;
  int byte_cnt;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  integer seed = 32'h7ADA;
  urc_pkg::urc_rx_t rx_seq [4] = '{12'h800, 12'hC00, 12'h200, 12'h000};

  always #5 ref_clk = ~ref_clk;

  urc_rxcmd u_dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_a(pins_a),
    .rx(rx), .tx_active(tx_active), .mode(mode), .pll_locked(pll_locked),
    .ulpi_stp(ulpi_stp), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .irq(irq)
  );

  urc_link_model u_link (
    .ref_clk(ref_clk), .reset(reset), .stp_go(stp_go), .ulpi_dir(ulpi_dir),
    .ulpi_nxt(ulpi_nxt), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_stp(ulpi_stp), .last_byte(last_byte), .byte_cnt(byte_cnt)
  );

  function automatic logic [7:0] exp_b(urc_pkg::urc_pins_t p, logic alt, logic otg);
    logic [1:0] v;
    logic [1:0] e;
    v = p.vbus_vld ? 2'h3 : p.sess_vld ? 2'h2 : p.sess_end ? 2'h0 : 2'h1;
    e = rx.host_disc ? 2'h2 : rx.active ? {rx.error, 1'b1} : 2'h0;
    return {alt, p.id & otg, e, v & {2{otg}}, p.dm, p.dp};
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic see(logic [7:0] exp);
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      if (last_byte === exp)
        break;
    end
    chk(last_byte, exp);
  endtask

  task automatic stp_pulse;
    @(posedge ref_clk);
    stp_go <= 1'b1;
    @(posedge ref_clk);
    stp_go <= 1'b0;
  endtask

  initial begin
    int base;
    logic [7:0] b;
    urc_pkg::urc_pins_t p;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({7'h0, ulpi_dir}, 8'h01);
    pll_locked <= 1'b1;
    see(exp_b(pins_a, 1'b0, 1'b1));
    rd(`URC_REG_IRQ_MASK, 8'h03);
    rd(`URC_REG_CTRL, 8'h02);
    rd(4'h2, 8'h00);
    wr(`URC_REG_IRQ_MASK, 8'h00);
    $display("startup and registers done");
    repeat (40) begin
      b = 8'($random(seed));
      p = pins_a;
      p.dp = b[0];
      p.dm = b[1];
      p.id = b[6];
      p.vbus_vld = (b[3:2] == 2'h3);
      p.sess_vld = b[3];
      p.sess_end = (b[3:2] == 2'h0);
      pins_a <= p;
      see(exp_b(p, 1'b0, 1'b1));
    end
    $display("random line and comparator done");
    for (int i = 0; i < 4; i++) begin
      rx <= rx_seq[i];
      @(posedge ref_clk);
      see(exp_b(pins_a, 1'b0, 1'b1));
      if (i == 0) begin
        base = byte_cnt;
        repeat (10) @(posedge ref_clk);
        chk(8'(byte_cnt - base), 8'h0A);
        rx <= 12'h9A5;
        // Read ahead of this edge's update, so the value is the one launched a cycle earlier
        repeat (3) @(posedge ref_clk);
        chk(ulpi_data_out, 8'hA5);
        chk({7'h0, ulpi_nxt}, 8'h01);
      end
    end
    $display("receive done");
    base = byte_cnt;
    tx_active <= 1'b1;
    pins_a.dp <= ~pins_a.dp;
    repeat (20) @(posedge ref_clk);
    chk(8'(byte_cnt - base), 8'h00);
    stp_pulse();
    see(exp_b(pins_a, 1'b0, 1'b1));
    tx_active <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      mode <= 3'h1 << m;
      stp_pulse();
      pins_a.dp <= ~pins_a.dp;
      base = byte_cnt;
      repeat (10) @(posedge ref_clk);
      chk(8'(byte_cnt - base), 8'h00);
      mode <= 3'h0;
      see(exp_b(pins_a, 1'b0, 1'b1));
    end
    $display("transmit and modes done");
    wr(`URC_REG_CTRL, 8'h01);
    see(exp_b(pins_a, 1'b0, 1'b0));
    wr(`URC_REG_CTRL, 8'h02);
    see(exp_b(pins_a, 1'b0, 1'b1));
    rd(`URC_REG_RXCMD, exp_b(pins_a, 1'b0, 1'b1));
    wr(`URC_REG_IRQ_STAT, 8'h0F);
    rd(`URC_REG_IRQ_STAT, 8'h00);
    wr(`URC_REG_IRQ_MASK, 8'h01);
    pins_a.id <= ~pins_a.id;
    @(posedge ref_clk);
    see(exp_b(pins_a, 1'b1, 1'b1));
    chk({7'h0, irq}, 8'h01);
    rd(`URC_REG_IRQ_STAT, 8'h01);
    wr(`URC_REG_IRQ_STAT, 8'h01);
    see(exp_b(pins_a, 1'b0, 1'b1));
    chk({7'h0, irq}, 8'h00);
    wr(`URC_REG_IRQ_MASK, 8'h02);
    pins_a.rid_done <= 1'b1;
    @(posedge ref_clk);
    see(exp_b(pins_a, 1'b1, 1'b1));
    rd(`URC_REG_IRQ_STAT, 8'h02);
    $display("interrupt done");
    conclude();
  end
endmodule // tb
